// ==== hdl/fsc_spinup_ctrl.sv ====
// fan spin-up sequencing and tachometer mode selection
// assumes register port and rpm logic share ref_clk; no synchronisers
module fsc_spinup_ctrl #(
	parameter int MS_DIV   = int'(fsc_pkg::MS_CYCLES),
	parameter int SLOW_DIV = int'(fsc_pkg::SLOW_DIV)
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic                  reg_wr,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	output logic [7:0]                 reg_rdata,
	input  wire logic [5:0]            pwm_cmd,
	input  wire logic                  tach_at_setpoint,
	output logic                       spin_active,
	output fsc_pkg::fsc_spin_duty_t    spin_duty,
	output fsc_pkg::fsc_tach_mode_t    tach_mode,
	output logic                       pwm_clk_en,
	output logic                       pwm_prog,
	output logic                       pwm_pol
);

	////////////////////////////////////////////////////////////////////////
	fsc_pkg::fsc_pwm_cfg_t  pwm_cfg_r;
	fsc_pkg::fsc_spin_cfg_t spin_cfg_r;
	fsc_pkg::fsc_state_t    state_r;
	logic [5:0]             cmd_prev_r;
	logic [11:0]            ms_cnt_r;
	logic [11:0]            spin_ms_lim;
	logic                   ms_tick;
	logic                   start_evt;
	logic                   bypass;
	logic                   spin_end;
	logic [fsc_pkg::DIV_W-1:0] pwm_period;

	localparam logic [fsc_pkg::DIV_W-1:0] MS_PERIOD =
		fsc_pkg::DIV_W'(MS_DIV);
	localparam logic [fsc_pkg::DIV_W-1:0] FAST_PERIOD =
		fsc_pkg::DIV_W'(fsc_pkg::FAST_DIV);
	localparam logic [fsc_pkg::DIV_W-1:0] SLOW_PERIOD =
		fsc_pkg::DIV_W'(SLOW_DIV);

	////////////////////////////////////////////////////////////////////////
	// register writes
	// reserved bit is not stored, so a stray one cannot steer anything
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pwm_cfg_r.prog     <= fsc_pkg::PWM_TACH_RST[fsc_pkg::PROG_BIT];
			pwm_cfg_r.pol      <= fsc_pkg::PWM_TACH_RST[fsc_pkg::POL_BIT];
			pwm_cfg_r.clk_slow <= fsc_pkg::PWM_TACH_RST[fsc_pkg::CLK_SEL_BIT];
			pwm_cfg_r.mode     <= fsc_pkg::fsc_tach_mode_t'(
				fsc_pkg::PWM_TACH_RST[fsc_pkg::TACH_MODE_LSB +: 2]);
		end else if (reg_wr && reg_addr == fsc_pkg::ADDR_PWM_TACH) begin
			pwm_cfg_r.prog     <= reg_wdata[fsc_pkg::PROG_BIT];
			pwm_cfg_r.pol      <= reg_wdata[fsc_pkg::POL_BIT];
			pwm_cfg_r.clk_slow <= reg_wdata[fsc_pkg::CLK_SEL_BIT];
			pwm_cfg_r.mode     <= fsc_pkg::fsc_tach_mode_t'(
				reg_wdata[fsc_pkg::TACH_MODE_LSB +: 2]);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			spin_cfg_r.fast      <= fsc_pkg::SPINUP_RST[fsc_pkg::FAST_BIT];
			spin_cfg_r.duty      <= fsc_pkg::fsc_spin_duty_t'(
				fsc_pkg::SPINUP_RST[fsc_pkg::DUTY_LSB +: 2]);
			spin_cfg_r.time_code <= fsc_pkg::SPINUP_RST[fsc_pkg::TIME_LSB +: 3];
		end else if (reg_wr && reg_addr == fsc_pkg::ADDR_SPINUP) begin
			spin_cfg_r.fast      <= reg_wdata[fsc_pkg::FAST_BIT];
			spin_cfg_r.duty      <= fsc_pkg::fsc_spin_duty_t'(
				reg_wdata[fsc_pkg::DUTY_LSB +: 2]);
			spin_cfg_r.time_code <= reg_wdata[fsc_pkg::TIME_LSB +: 3];
		end
	end

	assign pwm_prog = pwm_cfg_r.prog;
	assign pwm_pol  = pwm_cfg_r.pol;

	////////////////////////////////////////////////////////////////////////
	// register reads, one cycle after the address
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			unique case (reg_addr)
				fsc_pkg::ADDR_PWM_TACH: begin
					reg_rdata <= {2'h0, pwm_cfg_r.prog, pwm_cfg_r.pol,
						pwm_cfg_r.clk_slow, 1'b0, pwm_cfg_r.mode};
				end
				fsc_pkg::ADDR_SPINUP: begin
					reg_rdata <= {2'h0, spin_cfg_r};
				end
				fsc_pkg::ADDR_PWM_VALUE: begin
					reg_rdata <= (state_r == fsc_pkg::ST_SPIN) ?
						8'h00 : {2'h0, pwm_cmd};
				end
				default: begin
					reg_rdata <= 8'h00;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pwm master clock enable
	assign pwm_period = pwm_cfg_r.clk_slow ? SLOW_PERIOD : FAST_PERIOD;

	fsc_tick_div #(
		.W      (fsc_pkg::DIV_W)
	) u_pwm_div (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clr     (1'b0),
		.period  (pwm_period),
		.tick    (pwm_clk_en)
	);

	// millisecond tick restarted at spin start so durations are exact
	fsc_tick_div #(
		.W      (fsc_pkg::DIV_W)
	) u_ms_div (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clr     (start_evt),
		.period  (MS_PERIOD),
		.tick    (ms_tick)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tach_mode <= fsc_pkg::TACH_TRAD;
		end else if (!pwm_cfg_r.clk_slow) begin
			tach_mode <= fsc_pkg::TACH_TRAD;
		end else begin
			tach_mode <= pwm_cfg_r.mode;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// spin-up sequencing
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd_prev_r <= 6'h00;
		end else begin
			cmd_prev_r <= pwm_cmd;
		end
	end

	assign start_evt = (cmd_prev_r == 6'h00) && (pwm_cmd != 6'h00) &&
		(state_r == fsc_pkg::ST_RUN);
	assign bypass = (spin_cfg_r.time_code == 3'h0) ||
		(spin_cfg_r.duty == fsc_pkg::DUTY_NONE && !spin_cfg_r.fast);
	assign spin_ms_lim = fsc_pkg::SPIN_BASE_MS <<
		(spin_cfg_r.time_code - 3'h1);
	// dropping the command to zero aborts, so a restart spins up again
	assign spin_end = (ms_tick && ms_cnt_r + 12'h001 >= spin_ms_lim) ||
		(spin_cfg_r.fast && tach_at_setpoint) ||
		(pwm_cmd == 6'h00);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= fsc_pkg::ST_RUN;
		end else begin
			unique case (state_r)
				fsc_pkg::ST_RUN: begin
					if (start_evt && !bypass) begin
						state_r <= fsc_pkg::ST_SPIN;
					end
				end
				fsc_pkg::ST_SPIN: begin
					if (spin_end) begin
						state_r <= fsc_pkg::ST_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ms_cnt_r <= 12'h000;
		end else if (start_evt) begin
			ms_cnt_r <= 12'h000;
		end else if (ms_tick && state_r == fsc_pkg::ST_SPIN) begin
			ms_cnt_r <= ms_cnt_r + 12'h001;
		end
	end

	assign spin_active = (state_r == fsc_pkg::ST_SPIN);

	// downstream pwm generator turns the code into 50, 75-81 or 100 percent
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			spin_duty <= fsc_pkg::DUTY_NONE;
		end else if (!spin_active) begin
			spin_duty <= fsc_pkg::DUTY_NONE;
		end else if (spin_cfg_r.fast) begin
			spin_duty <= fsc_pkg::DUTY_FULL;
		end else begin
			spin_duty <= spin_cfg_r.duty;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_mode_fast_clk: assert property (@(posedge ref_clk) disable iff (rst)
		!pwm_cfg_r.clk_slow |=> tach_mode == fsc_pkg::TACH_TRAD)
		else $error("tach mode not forced on fast clock");

	a_mode_slow_clk: assert property (@(posedge ref_clk) disable iff (rst)
		pwm_cfg_r.clk_slow |=> tach_mode == $past(pwm_cfg_r.mode))
		else $error("tach mode does not follow field");

	a_skip_time: assert property (@(posedge ref_clk) disable iff (rst)
		start_evt && spin_cfg_r.time_code == 3'h0 |=> !spin_active)
		else $error("spin-up not skipped for time zero");

	a_skip_duty: assert property (@(posedge ref_clk) disable iff (rst)
		start_evt && spin_cfg_r.duty == fsc_pkg::DUTY_NONE &&
		!spin_cfg_r.fast |=> !spin_active)
		else $error("spin-up not skipped for duty zero");

	a_start_spin: assert property (@(posedge ref_clk) disable iff (rst)
		start_evt && !bypass |=> spin_active)
		else $error("spin-up did not start");

	a_tach_end: assert property (@(posedge ref_clk) disable iff (rst)
		spin_active && spin_cfg_r.fast && tach_at_setpoint |=> !spin_active)
		else $error("fast spin-up did not end on tach");

	a_fast_full: assert property (@(posedge ref_clk) disable iff (rst)
		spin_active && spin_cfg_r.fast |=> spin_duty == fsc_pkg::DUTY_FULL)
		else $error("fast spin-up not at full duty");

	a_spin_duty: assert property (@(posedge ref_clk) disable iff (rst)
		spin_active && !spin_cfg_r.fast |=> spin_duty == $past(spin_cfg_r.duty))
		else $error("spin duty code wrong");

	a_value_zero: assert property (@(posedge ref_clk) disable iff (rst)
		spin_active && reg_addr == fsc_pkg::ADDR_PWM_VALUE |=> reg_rdata == 8'h00)
		else $error("pwm value not zero in spin-up");

	a_cfg_top_zero: assert property (@(posedge ref_clk) disable iff (rst)
		reg_addr == fsc_pkg::ADDR_SPINUP |=> reg_rdata[7:6] == 2'h0)
		else $error("spin-up register top bits not zero");

	a_time_limit: assert property (@(posedge ref_clk) disable iff (rst)
		spin_active |-> ms_cnt_r < spin_ms_lim)
		else $error("spin-up overran its duration");

endmodule

// ==== hdl/fsc_pkg.sv ====
// shared constants, register layouts and types of the fan spin-up block
// assumes a single 100 MHz clock; serial host access decoded elsewhere
package fsc_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADDR_PWM_TACH  = 8'h4a;
	localparam logic [7:0] ADDR_SPINUP    = 8'h4b;
	localparam logic [7:0] ADDR_PWM_VALUE = 8'h4c;

	localparam logic [7:0] PWM_TACH_RST = 8'h20;
	localparam logic [7:0] SPINUP_RST   = 8'h3f;

	// pwm and tachometer configuration fields
	localparam int TACH_MODE_LSB = 0;
	localparam int RSV_BIT       = 2;
	localparam int CLK_SEL_BIT   = 3;
	localparam int POL_BIT       = 4;
	localparam int PROG_BIT      = 5;
	// spin-up configuration fields
	localparam int TIME_LSB = 0;
	localparam int DUTY_LSB = 3;
	localparam int FAST_BIT = 5;

	////////////////////////////////////////////////////////////////////////
	localparam longint CLK_HZ        = 100000000;
	localparam longint CLK_PERIOD_NS = 10;
	localparam longint MS_NS         = 1000000;
	localparam longint MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam longint FAST_CLK_HZ   = 360000;
	localparam longint SLOW_CLK_HZ   = 1400;
	localparam longint FAST_DIV      = CLK_HZ / FAST_CLK_HZ;
	localparam longint SLOW_DIV      = CLK_HZ / SLOW_CLK_HZ;
	localparam logic [11:0] SPIN_BASE_MS = 12'h032;
	localparam int DIV_W = 20;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		TACH_TRAD        = 2'h0,
		TACH_TRAD_SAT    = 2'h1,
		TACH_ACCURATE    = 2'h2,
		TACH_LOW_DISTURB = 2'h3
	} fsc_tach_mode_t;

	typedef enum logic [1:0] {
		DUTY_NONE  = 2'h0,
		DUTY_HALF  = 2'h1,
		DUTY_3Q    = 2'h2,
		DUTY_FULL  = 2'h3
	} fsc_spin_duty_t;

	typedef enum logic {
		ST_RUN  = 1'b0,
		ST_SPIN = 1'b1
	} fsc_state_t;

	typedef struct packed {
		logic           fast;
		fsc_spin_duty_t duty;
		logic [2:0]     time_code;
	} fsc_spin_cfg_t;

	typedef struct packed {
		logic           prog;
		logic           pol;
		logic           clk_slow;
		fsc_tach_mode_t mode;
	} fsc_pwm_cfg_t;

endpackage

// ==== hdl/fsc_tick_div.sv ====
// programmable divider giving one-cycle enable pulses
// assumes period is held steady; clr restarts the phase
module fsc_tick_div #(
	parameter int W = 20
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         clr,
	input  wire logic [W-1:0] period,
	output logic              tick
);

	logic [W-1:0] cnt_r;
	logic         wrap;

	assign wrap = (cnt_r >= period - W'(1));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (clr || wrap) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + W'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tick <= 1'b0;
		end else begin
			tick <= wrap && !clr;
		end
	end

endmodule

// ==== tb/fsc_fan_model.sv ====
// fan partner: reports setpoint speed after a fixed spin delay
// assumes spin_active from the block under test, same clock
module fsc_fan_model #(
	parameter int DLY = 200
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic spin_active,
	output logic      tach_at_setpoint
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_r;
	// speed builds only while driven; coasts below setpoint otherwise
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			cnt_r <= 0;
		else if (!spin_active)
			cnt_r <= 0;
		else if (cnt_r < DLY)
			cnt_r <= cnt_r + 1;
	end
	assign tach_at_setpoint = (cnt_r >= DLY);
endmodule

// ==== tb/tb_fan_spinup_tach_mode_ctrl.sv ====
// self-checking bench for the fan spin-up and tach mode block
// assumes fan model in tb/, shortened ms and slow-clock divides
module tb_fan_spinup_tach_mode_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MSD = 10;
	localparam int SDV = 20;
	localparam int DLY = 200;
	// fast, duty code, time code
	localparam logic [5:0] CASES [7] = '{6'h09, 6'h12, 6'h19, 6'h21,
		6'h2b, 6'h07, 6'h38};
	logic                    ref_clk = 1'b0;
	logic                    rst = 1'b1;
	logic                    reg_wr = 1'b0;
	logic [7:0]              reg_addr = 8'h00;
	logic [7:0]              reg_wdata = 8'h00;
	logic [5:0]              pwm_cmd = 6'h00;
	logic [7:0]              reg_rdata;
	logic                    tach, spin_active, pwm_clk_en;
	fsc_pkg::fsc_spin_duty_t spin_duty;
	fsc_pkg::fsc_tach_mode_t tach_mode;
	logic                    pend = 1'b0;
	logic                    pend_d = 1'b0;
	logic [9:0]              q[$];
	logic [9:0]              e;
	logic [5:0]              cf;
	logic                    sk;
	int n_fail = 0, total_checks = 0, cyc = 0, seed = 32'h40d2;
	int i, t0, dur, ex;

	fsc_spinup_ctrl #(.MS_DIV(MSD), .SLOW_DIV(SDV)) dut (
		.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .pwm_cmd(pwm_cmd),
		.tach_at_setpoint(tach), .spin_active(spin_active),
		.spin_duty(spin_duty), .tach_mode(tach_mode),
		.pwm_clk_en(pwm_clk_en), .pwm_prog(), .pwm_pol());
	fsc_fan_model #(.DLY(DLY)) fan (.ref_clk(ref_clk), .rst(rst),
		.spin_active(spin_active), .tach_at_setpoint(tach));

	always #5 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic results();
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// kind 0 read data, 1 spin flag, 2 spin duty, 3 tach mode
	task automatic probe(logic [1:0] kd, logic [7:0] a, logic [7:0] x);
		@(posedge ref_clk);
		reg_addr <= a;
		pend <= 1'b1;
		q.push_back({kd, x});
		@(posedge ref_clk);
		pend <= 1'b0;
	endtask
	task automatic pulse();
		do @(posedge ref_clk); while (pwm_clk_en !== 1'b1);
	endtask
	// skip one interval so a select change cannot shorten the count
	task automatic per(int x);
		int n;
		pulse();
		pulse();
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pwm_clk_en !== 1'b1);
		check("clk_period", 16'(n), 16'(x));
	endtask

	////////////////////////////////////////////////////////////////////////
	// read data lands one cycle after the address, so compare a cycle late
	always @(posedge ref_clk) begin
		pend_d <= pend;
		if (pend_d) begin
			e = q.pop_front();
			case (e[9:8])
			2'h0: check("reg_rdata", 16'(reg_rdata), 16'(e[7:0]));
			2'h1: check("spin_active", 16'(spin_active), 16'(e[7:0]));
			2'h2: check("spin_duty", 16'(spin_duty), 16'(e[7:0]));
			default: check("tach_mode", 16'(tach_mode), 16'(e[7:0]));
			endcase
		end
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		probe(0, fsc_pkg::ADDR_PWM_TACH, fsc_pkg::PWM_TACH_RST);
		probe(0, fsc_pkg::ADDR_SPINUP, fsc_pkg::SPINUP_RST);
		probe(0, 8'h10, 8'h00);
		per(277);
		wr(8'h55, 8'($random(seed)));
		wr(fsc_pkg::ADDR_SPINUP, 8'hff);
		probe(0, fsc_pkg::ADDR_SPINUP, 8'h3f);
		for (i = 0; i < 8; i++) begin
			wr(fsc_pkg::ADDR_PWM_TACH, {4'h2, i[2], 1'b0, i[1:0]});
			probe(3, 8'h00, i[2] ? {6'h0, i[1:0]} : 8'h00);
		end
		per(SDV);
		wr(fsc_pkg::ADDR_PWM_TACH, 8'h20);
		foreach (CASES[c]) begin
			cf = CASES[c];
			sk = (cf[2:0] == 3'h0) || (cf[4:3] == 2'h0 && !cf[5]);
			wr(fsc_pkg::ADDR_SPINUP, {2'h0, cf});
			pwm_cmd <= 6'($random(seed)) | 6'h01;
			t0 = cyc;
			repeat (4) @(posedge ref_clk);
			probe(1, 8'h00, {7'h0, !sk});
			probe(2, 8'h00, sk ? 8'h0 : cf[5] ? 8'h3 : {6'h0, cf[4:3]});
			if (!sk) begin
				probe(0, fsc_pkg::ADDR_PWM_VALUE, 8'h00);
				while (spin_active === 1'b1)
					@(posedge ref_clk);
				dur = cyc - t0;
				ex = cf[5] ? DLY : (50 << (cf[2:0] - 1)) * MSD;
				check("spin_len", 16'(dur >= ex && dur <= ex + 4), 16'h1);
				probe(2, 8'h00, 8'h00);
			end
			pwm_cmd <= 6'h00;
			repeat (2) @(posedge ref_clk);
		end
		// dropping the command mid spin-up must end it
		wr(fsc_pkg::ADDR_SPINUP, 8'h3f);
		pwm_cmd <= 6'h21;
		repeat (20) @(posedge ref_clk);
		pwm_cmd <= 6'h00;
		repeat (4) @(posedge ref_clk);
		probe(1, 8'h00, 8'h00);
		repeat (4) @(posedge ref_clk);
		results();
	end
endmodule
